/* File: shared/cc_pkg.sv */
// Constants, types and helpers shared by the color corrector files
package cc_pkg;
  localparam int PIX_W = 10;
  localparam int COMP_N = 3;
  localparam int SRC_N = 4;
  localparam int SRC_W = 2;
  localparam int ENTRY_N = SRC_N * COMP_N;
  localparam int ADDR_W = 8;
  localparam int FIELD_W = 12;
  localparam int LAT = 5;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_LIFT = 8'h0C;
  localparam logic [7:0] ADDR_GAMMA = 8'h10;
  localparam logic [7:0] ADDR_WHITE = 8'h14;
  localparam logic [7:0] ADDR_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // Control and status field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_LINK_LSB = 4;
  localparam int CTRL_MODE_BIT = 8;
  localparam int CTRL_UNITY_BIT = 9;
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_EN_LSB = 4;

  // Control ranges, percent or IRE
  localparam int GAIN_MIN = 0;
  localparam int GAIN_MAX = 200;
  localparam int GAIN_NOM = 100;
  localparam int LIFT_MIN = -40;
  localparam int LIFT_MAX = 100;
  localparam int LIFT_NOM = 0;
  localparam int GAMMA_MIN = -100;
  localparam int GAMMA_MAX = 100;
  localparam int GAMMA_NOM = 0;
  localparam int BLACK_MIN = -40;
  localparam int BLACK_MAX = 100;
  localparam int WHITE_MIN = -40;
  localparam int WHITE_MAX = 300;

  // Video codes and fixed-point scaling
  localparam int BLACK_CODE = 64;
  localparam int SPAN_CODE = 876;
  localparam int MID_CODE = 512;
  localparam int CLIP_LO = 4;
  localparam int CLIP_HI = 1019;
  localparam int GAMMA_RECIP = 48;
  localparam int GAMMA_SHIFT = 22;
  localparam int GAIN_RECIP = 41;
  localparam int GAIN_SHIFT = 12;
  localparam int LIFT_SCALE = 35;
  localparam int LIFT_SHIFT = 2;
  localparam int COEF_SHIFT = 8;
  localparam int COEF_RV = 403;
  localparam int COEF_GU = 48;
  localparam int COEF_GV = 120;
  localparam int COEF_BU = 475;
  localparam int COEF_YR = 54;
  localparam int COEF_YG = 183;
  localparam int COEF_YB = 19;
  localparam int COEF_CB = 138;
  localparam int COEF_CR = 163;

  typedef logic signed [PIX_W-1:0] pval_t;
  typedef enum logic [1:0] {
    COMP_RED = 2'b00,
    COMP_GREEN = 2'b01,
    COMP_BLUE = 2'b10
  } comp_t;
  typedef enum logic {
    MODE_GAIN_LIFT = 1'b0,
    MODE_WHITE_BLACK = 1'b1
  } knob_mode_t;

  function automatic logic [PIX_W-1:0] clip_pix(
    input logic signed [21:0] v
  );
    if (v < 22'(CLIP_LO)) return PIX_W'(CLIP_LO);
    if (v > 22'(CLIP_HI)) return PIX_W'(CLIP_HI);
    return v[PIX_W-1:0];
  endfunction

  function automatic logic signed [FIELD_W-1:0] clamp_f(
    input logic signed [FIELD_W-1:0] v,
    input int lo,
    input int hi
  );
    if (v < FIELD_W'(lo)) return FIELD_W'(lo);
    if (v > FIELD_W'(hi)) return FIELD_W'(hi);
    return v;
  endfunction
endpackage

/* File: rtl/comp_proc.sv */
// One color component: gamma, gain, lift and limiter, three stages
`timescale 1ns/1ps
module comp_proc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cc_pkg::PIX_W-1:0] x,
  input wire logic en,
  input wire cc_pkg::pval_t gain,
  input wire cc_pkg::pval_t lift,
  input wire cc_pkg::pval_t gamma,
  output logic [cc_pkg::PIX_W-1:0] y
);
  import cc_pkg::*;

  logic signed [21:0] n1, bend1, c2;
  pval_t gain1, lift1, gam1, gain2, lift2;
  logic [PIX_W-1:0] x1, x2;
  logic en1, en2;

  // Black-referenced input; bend is zero at black and white
  wire signed [21:0] n = 22'($signed({1'b0, x})) - 22'(BLACK_CODE);
  wire signed [21:0] bend = 22'(n * (22'(SPAN_CODE) - n));
  wire signed [39:0] gp = 40'(bend1) * 40'(gam1) * 40'(GAMMA_RECIP);
  wire signed [21:0] curve = n1 + 22'(gp >>> GAMMA_SHIFT);
  wire signed [39:0] sc = 40'(c2) * 40'(gain2) * 40'(GAIN_RECIP);
  wire signed [39:0] lp = 40'(lift2) * 40'(LIFT_SCALE);
  wire signed [21:0] lv = 22'(lp >>> LIFT_SHIFT);
  // Zero gain leaves only lift: a flat line
  wire signed [21:0] v = 22'(sc >>> GAIN_SHIFT) + lv +
    22'(BLACK_CODE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n1 <= '0;
      bend1 <= '0;
      gain1 <= '0;
      lift1 <= '0;
      gam1 <= '0;
      x1 <= '0;
      en1 <= 1'b0;
    end else begin
      n1 <= n;
      bend1 <= bend;
      gain1 <= gain;
      lift1 <= lift;
      gam1 <= gamma;
      x1 <= x;
      en1 <= en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2 <= '0;
      gain2 <= '0;
      lift2 <= '0;
      x2 <= '0;
      en2 <= 1'b0;
    end else begin
      c2 <= curve;
      gain2 <= gain1;
      lift2 <= lift1;
      x2 <= x1;
      en2 <= en1;
    end
  end

  // Bypass selects at the last stage so latency never changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y <= '0;
    end else begin
      y <= en2 ? clip_pix(v) : x2;
    end
  end
endmodule

/* File: rtl/rgb_color_corrector.sv */
// Per-source RGB color corrector with APB parameter registers
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module rgb_color_corrector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cc_pkg::SRC_W-1:0] route_src,
  input wire logic vid_valid_in,
  input wire logic [cc_pkg::PIX_W-1:0] y_in,
  input wire logic [cc_pkg::PIX_W-1:0] cb_in,
  input wire logic [cc_pkg::PIX_W-1:0] cr_in,
  output logic vid_valid_out,
  output logic [cc_pkg::PIX_W-1:0] y_out,
  output logic [cc_pkg::PIX_W-1:0] cb_out,
  output logic [cc_pkg::PIX_W-1:0] cr_out
);
  import cc_pkg::*;

  pval_t gain_q [ENTRY_N];
  pval_t lift_q [ENTRY_N];
  pval_t gamma_q [ENTRY_N];
  logic [COMP_N-1:0] enable_q [SRC_N];
  comp_t sel;
  logic [COMP_N-1:0] link;
  knob_mode_t mode;
  logic [SRC_W-1:0] edit_src;
  logic [SRC_W-1:0] route_a;
  logic [LAT-1:0] valid_pipe;
  logic [PIX_W-1:0] rgb_a [COMP_N];
  logic [PIX_W-1:0] rgb_p [COMP_N];

  function automatic int entry_idx(
    input logic [SRC_W-1:0] s,
    input int c
  );
    return int'(s) * COMP_N + c;
  endfunction

  // Selected component or a component linked to it
  function automatic logic in_group(input int c);
    return (c == int'(sel)) || link[c];
  endfunction

  // APB decode
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire setup_rd = psel & ~penable & ~pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_src = paddr == ADDR_SRC;
  wire hit_gain = paddr == ADDR_GAIN;
  wire hit_lift = paddr == ADDR_LIFT;
  wire hit_gamma = paddr == ADDR_GAMMA;
  wire hit_white = paddr == ADDR_WHITE;
  wire hit_enable = paddr == ADDR_ENABLE;
  wire hit_status = paddr == ADDR_STATUS;
  wire known = hit_ctrl | hit_src | hit_gain | hit_lift | hit_gamma |
    hit_white | hit_enable | hit_status;

  // Zero-wait slave; read data was latched during setup
  assign pready = access;
  assign pslverr = access & ~known;

  wire signed [FIELD_W-1:0] wfield = $signed(pwdata[FIELD_W-1:0]);
  wire [1:0] new_sel_raw = pwdata[CTRL_SEL_LSB +: 2];
  wire sel_legal = new_sel_raw != 2'b11;
  wire comp_t new_sel = sel_legal ? comp_t'(new_sel_raw) : sel;
  wire [COMP_N-1:0] sel_bit = COMP_N'(1) << sel;
  wire [COMP_N-1:0] new_link = pwdata[CTRL_LINK_LSB +: COMP_N] &
    ~sel_bit;
  wire unity_req = wr & hit_ctrl & pwdata[CTRL_UNITY_BIT];

  // Write clamps shared by all entries
  wire signed [FIELD_W-1:0] gain_w = clamp_f(wfield, GAIN_MIN,
    GAIN_MAX);
  wire signed [FIELD_W-1:0] lift_w = clamp_f(wfield, LIFT_MIN,
    LIFT_MAX);
  wire signed [FIELD_W-1:0] gamma_w = clamp_f(wfield, GAMMA_MIN,
    GAMMA_MAX);
  wire signed [FIELD_W-1:0] black_w = clamp_f(wfield, BLACK_MIN,
    BLACK_MAX);
  wire signed [FIELD_W-1:0] white_w = clamp_f(wfield, WHITE_MIN,
    WHITE_MAX);

  // Control register: component select, links, knob mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= COMP_RED;
      link <= '0;
      mode <= MODE_GAIN_LIFT;
    end else if (wr && hit_ctrl) begin
      sel <= new_sel;
      link <= (new_sel != sel) ? '0 : new_link;
      mode <= knob_mode_t'(pwdata[CTRL_MODE_BIT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edit_src <= '0;
    end else if (wr && hit_src) begin
      edit_src <= pwdata[SRC_W-1:0];
    end
  end

  // Enables live apart from parameters, so values survive
  genvar gs;
  generate
    for (gs = 0; gs < SRC_N; gs++) begin : g_en
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enable_q[gs] <= '0;
        end else if (wr && hit_enable && edit_src == SRC_W'(gs)) begin
          enable_q[gs] <= pwdata[COMP_N-1:0];
        end
      end
    end
  endgenerate

  // Parameter store: one entry per source and component
  genvar gi;
  generate
    for (gi = 0; gi < ENTRY_N; gi++) begin : g_ent
      localparam int SI = gi / COMP_N;
      localparam int CI = gi % COMP_N;
      wire tgt = (edit_src == SRC_W'(SI)) && in_group(CI);
      wire signed [FIELD_W-1:0] lift_x = FIELD_W'(lift_q[gi]);
      wire signed [FIELD_W-1:0] gain_x = FIELD_W'(gain_q[gi]);
      wire signed [FIELD_W-1:0] white_cur = lift_x + gain_x;
      // Black move keeps white fixed; white move keeps black fixed
      wire signed [FIELD_W-1:0] gain_fb = clamp_f(white_cur - black_w,
        GAIN_MIN, GAIN_MAX);
      wire signed [FIELD_W-1:0] gain_fw = clamp_f(white_w - lift_x,
        GAIN_MIN, GAIN_MAX);
      wire wb = mode == MODE_WHITE_BLACK;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gain_q[gi] <= PIX_W'(GAIN_NOM);
          lift_q[gi] <= PIX_W'(LIFT_NOM);
          gamma_q[gi] <= PIX_W'(GAMMA_NOM);
        end else if (unity_req && tgt) begin
          gain_q[gi] <= PIX_W'(GAIN_NOM);
          lift_q[gi] <= PIX_W'(LIFT_NOM);
          gamma_q[gi] <= PIX_W'(GAMMA_NOM);
        end else if (wr && tgt) begin
          if (hit_gain) begin
            gain_q[gi] <= gain_w[PIX_W-1:0];
          end
          if (hit_gamma) begin
            gamma_q[gi] <= gamma_w[PIX_W-1:0];
          end
          if (hit_lift && !wb) begin
            lift_q[gi] <= lift_w[PIX_W-1:0];
          end
          if (hit_lift && wb) begin
            lift_q[gi] <= black_w[PIX_W-1:0];
            gain_q[gi] <= gain_fb[PIX_W-1:0];
          end
          if (hit_white) begin
            gain_q[gi] <= gain_fw[PIX_W-1:0];
          end
        end
      end
    end
  endgenerate

  // Read mux
  wire [3:0] sel_idx = 4'(entry_idx(edit_src, int'(sel)));
  wire signed [FIELD_W-1:0] white_rd = FIELD_W'(lift_q[sel_idx]) +
    FIELD_W'(gain_q[sel_idx]);
  wire [31:0] ctrl_rd = 32'(sel) | (32'(link) << CTRL_LINK_LSB) |
    (32'(mode) << CTRL_MODE_BIT);
  wire [31:0] status_rd = (32'(route_a) << STAT_SRC_LSB) |
    (32'(enable_q[route_a]) << STAT_EN_LSB);
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_src ? 32'(edit_src) :
    hit_gain ? 32'(gain_q[sel_idx]) :
    hit_lift ? 32'(lift_q[sel_idx]) :
    hit_gamma ? 32'(gamma_q[sel_idx]) :
    hit_white ? 32'(white_rd) :
    hit_enable ? 32'(enable_q[edit_src]) :
    hit_status ? status_rd : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

  // Stage A: color difference to RGB, offset binary chroma
  wire signed [21:0] yd = 22'($signed({1'b0, y_in}));
  wire signed [21:0] cbd = 22'($signed({1'b0, cb_in})) - 22'(MID_CODE);
  wire signed [21:0] crd = 22'($signed({1'b0, cr_in})) - 22'(MID_CODE);
  wire signed [21:0] r_c = yd + 22'((crd * 22'(COEF_RV)) >>> COEF_SHIFT);
  wire signed [21:0] g_c = yd -
    22'((cbd * 22'(COEF_GU) + crd * 22'(COEF_GV)) >>> COEF_SHIFT);
  wire signed [21:0] b_c = yd + 22'((cbd * 22'(COEF_BU)) >>> COEF_SHIFT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_a[COMP_RED] <= '0;
      rgb_a[COMP_GREEN] <= '0;
      rgb_a[COMP_BLUE] <= '0;
      route_a <= '0;
    end else begin
      rgb_a[COMP_RED] <= clip_pix(r_c);
      rgb_a[COMP_GREEN] <= clip_pix(g_c);
      rgb_a[COMP_BLUE] <= clip_pix(b_c);
      route_a <= route_src;
    end
  end

  // Per-component processors use the routed source's set
  genvar gc;
  generate
    for (gc = 0; gc < COMP_N; gc++) begin : g_comp
      wire [3:0] ridx = 4'(entry_idx(route_a, gc));
      comp_proc u_proc (
        .pclk(pclk),
        .presetn(presetn),
        .x(rgb_a[gc]),
        .en(enable_q[route_a][gc]),
        .gain(gain_q[ridx]),
        .lift(lift_q[ridx]),
        .gamma(gamma_q[ridx]),
        .y(rgb_p[gc])
      );
    end
  endgenerate

  // Stage B: RGB back to color difference
  wire signed [21:0] rp = 22'($signed({1'b0, rgb_p[COMP_RED]}));
  wire signed [21:0] gp = 22'($signed({1'b0, rgb_p[COMP_GREEN]}));
  wire signed [21:0] bp = 22'($signed({1'b0, rgb_p[COMP_BLUE]}));
  wire signed [21:0] y_c = 22'((rp * 22'(COEF_YR) + gp * 22'(COEF_YG) +
    bp * 22'(COEF_YB)) >>> COEF_SHIFT);
  wire signed [21:0] cb_c = 22'(((bp - y_c) * 22'(COEF_CB)) >>>
    COEF_SHIFT) + 22'(MID_CODE);
  wire signed [21:0] cr_c = 22'(((rp - y_c) * 22'(COEF_CR)) >>>
    COEF_SHIFT) + 22'(MID_CODE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_out <= '0;
      cb_out <= '0;
      cr_out <= '0;
    end else begin
      y_out <= clip_pix(y_c);
      cb_out <= clip_pix(cb_c);
      cr_out <= clip_pix(cr_c);
    end
  end

  // Valid tracks the fixed pipeline depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_pipe <= '0;
    end else begin
      valid_pipe <= {valid_pipe[LAT-2:0], vid_valid_in};
    end
  end

  assign vid_valid_out = valid_pipe[LAT-1];
endmodule

/* File: test/rgb_color_corrector_checker.sv */
// Port-level assertions for the color corrector
`timescale 1ns/1ps
module rgb_color_corrector_checker
  import cc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [cc_pkg::SRC_W-1:0] route_src,
  input wire logic vid_valid_in,
  input wire logic vid_valid_out,
  input wire logic [cc_pkg::PIX_W-1:0] y_out
);
  // Age since reset keeps $past away from values held in reset
  logic [2:0] age;
  wire acc = psel && penable;
  wire settled = age == 3'h6;
  wire stat_rd = acc && !pwrite && paddr == ADDR_STATUS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= 3'h0;
    end else if (!settled) begin
      age <= age + 3'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_valid_delay: assert property (
    settled |-> vid_valid_out == $past(vid_valid_in, 5))
    else $error("video valid delay wrong");
  a_ready_now: assert property (pready == acc)
    else $error("pready not with access phase");
  a_idle_quiet: assert property (!psel |-> !pslverr)
    else $error("error response while idle");
  a_slverr_map: assert property (
    acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_STATUS))
    else $error("error response on wrong address");
  a_err_zero: assert property (
    acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_rdata_hold: assert property (
    $changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_out_clip: assert property (
    settled && vid_valid_out |-> y_out >= CLIP_LO && y_out <= CLIP_HI)
    else $error("luma outside limiter range");
  a_status_src: assert property (
    settled && stat_rd && $stable(route_src) &&
    route_src == $past(route_src, 2) && route_src == $past(route_src, 3)
    |-> prdata[1:0] == route_src)
    else $error("status shows wrong source");
endmodule
bind rgb_color_corrector rgb_color_corrector_checker chk_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .route_src, .vid_valid_in, .vid_valid_out, .y_out);

/* File: test/video_feed.sv */
// Upstream video stage model: registers the pixel it is handed
`timescale 1ns/1ps
module video_feed (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cc_pkg::PIX_W-1:0] ty,
  input wire logic [cc_pkg::PIX_W-1:0] tcb,
  input wire logic [cc_pkg::PIX_W-1:0] tcr,
  output logic vid_valid_in,
  output logic [cc_pkg::PIX_W-1:0] y_in,
  output logic [cc_pkg::PIX_W-1:0] cb_in,
  output logic [cc_pkg::PIX_W-1:0] cr_in
);
  import cc_pkg::*;
  // Valid toggles so the delay check sees both edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vid_valid_in <= 1'b0;
      {y_in, cb_in, cr_in} <= '0;
    end else begin
      vid_valid_in <= ~vid_valid_in;
      {y_in, cb_in, cr_in} <= {ty, tcb, tcr};
    end
  end
endmodule

/* File: test/rgb_color_corrector_test.sv */
// Self-checking bench for the color corrector
`timescale 1ns/1ps
module rgb_color_corrector_test;
  import cc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] route_src = 2'h0;
  logic [9:0] ty = 10'h200, tcb = 10'h200, tcr = 10'h200;
  logic [31:0] prdata, rv;
  logic pready, pslverr, last_err, vid_valid_in, vid_valid_out;
  logic [9:0] y_in, cb_in, cr_in, y_out, cb_out, cr_out;
  integer seed = 32'hE202;
  int bad_count = 0;
  int checks_done = 0;
  int k, x, g, lf;
  int cv [6] = '{250, -5, -50, 120, 150, -150};
  int ce [6] = '{200, 0, -40, 100, 100, -100};
  int tg [6] = '{0, 0, 200, 50, 100, 0};
  int tl [6] = '{0, 100, 100, -40, 35, 0};
  always #25 pclk = ~pclk;
  rgb_color_corrector uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .route_src,
    .vid_valid_in, .y_in, .cb_in, .cr_in, .vid_valid_out, .y_out,
    .cb_out, .cr_out);
  video_feed feed (.pclk, .presetn, .ty, .tcb, .tcr, .vid_valid_in,
    .y_in, .cb_in, .cr_in);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Fixed-point gain and matrix leave a few codes of slack
  task automatic near(input logic [9:0] s, input int e);
    chk({31'h0, int'(s) > e - 5 && int'(s) < e + 5}, 32'h1);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) bad_count++;
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask
  task automatic rdchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk({20'h0, rv[11:0]}, {20'h0, 12'(e)});
  endtask
  // Pixel held long enough to cross feed stage and pipeline
  task automatic show(input int yy, input int b, input int r);
    @(posedge pclk);
    ty <= 10'(yy);
    tcb <= 10'(b);
    tcr <= 10'(r);
    repeat (9) @(posedge pclk);
  endtask
  task automatic rgbchk(input int r, input int gg, input int b);
    int yy;
    yy = 64 + (COEF_YR * (r - 64) + COEF_YG * (gg - 64)
      + COEF_YB * (b - 64)) / 256;
    near(y_out, yy);
    near(cb_out, 512 + COEF_CB * (b - yy) / 256);
    near(cr_out, 512 + COEF_CR * (r - yy) / 256);
  endtask
  task automatic gray(input int xx, input int e);
    show(xx, 512, 512);
    rgbchk(e, e, e);
  endtask
  function automatic int lvl(input int gn, input int lt, input int xx);
    int v;
    v = 64 + gn * (xx - 64) / 100 + lt * SPAN_CODE / 100;
    return v < CLIP_LO ? CLIP_LO : (v > CLIP_HI ? CLIP_HI : v);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ADDR_GAIN, GAIN_NOM);
    rdchk(ADDR_LIFT, LIFT_NOM);
    rdchk(ADDR_GAMMA, GAMMA_NOM);
    rdchk(ADDR_ENABLE, 0);
    $display("test reset done");
    // Chroma kept near neutral so RGB stays inside the gamut
    for (k = 0; k < 6; k++) begin
      x = 300 + {$random(seed)} % 400;
      g = 462 + {$random(seed)} % 100;
      lf = 462 + {$random(seed)} % 100;
      show(x, g, lf);
      near(y_out, x);
      near(cb_out, g);
      near(cr_out, lf);
    end
    $display("test bypass done");
    wr(ADDR_CTRL, 32'h60);
    for (k = 0; k < 6; k++) begin
      wr(ADDR_GAIN + 8'(4 * (k / 2)), cv[k]);
      rdchk(ADDR_GAIN + 8'(4 * (k / 2)), ce[k]);
    end
    wr(ADDR_GAMMA, 0);
    wr(ADDR_ENABLE, 7);
    for (k = 0; k < 6; k++) begin
      g = tg[k];
      lf = tl[k];
      if (k == 5) begin
        g = {$random(seed)} % 201;
        lf = int'({$random(seed)} % 141) - 40;
      end
      wr(ADDR_GAIN, g);
      wr(ADDR_LIFT, lf);
      x = 64 + {$random(seed)} % 877;
      gray(x, lvl(g, lf, x));
    end
    $display("test transfer done");
    wr(ADDR_GAIN, 0);
    wr(ADDR_LIFT, 50);
    wr(ADDR_ENABLE, 0);
    gray(600, 600);
    rdchk(ADDR_LIFT, 50);
    wr(ADDR_ENABLE, 7);
    gray(600, lvl(0, 50, 600));
    wr(ADDR_GAIN, 100);
    wr(ADDR_LIFT, 0);
    wr(ADDR_GAMMA, 100);
    show(502, 512, 512);
    chk({31'h0, y_out > 10'h1FE}, 32'h1);
    wr(ADDR_GAMMA, -100);
    show(502, 512, 512);
    chk({31'h0, y_out < 10'h1EE}, 32'h1);
    $display("test gamma done");
    wr(ADDR_GAIN, 30);
    wr(ADDR_CTRL, 32'h260);
    rdchk(ADDR_GAIN, GAIN_NOM);
    gray(502, 502);
    wr(ADDR_CTRL, 32'h1);
    rdchk(ADDR_GAMMA, GAMMA_NOM);
    wr(ADDR_GAIN, 0);
    show(502, 512, 512);
    rgbchk(502, 64, 502);
    wr(ADDR_CTRL, 32'h0);
    rdchk(ADDR_GAIN, GAIN_NOM);
    $display("test unity done");
    wr(ADDR_CTRL, 32'h160);
    wr(ADDR_LIFT, 10);
    wr(ADDR_WHITE, 80);
    rdchk(ADDR_GAIN, 70);
    rdchk(ADDR_WHITE, 80);
    gray(940, lvl(70, 10, 940));
    wr(ADDR_WHITE, 300);
    rdchk(ADDR_WHITE, 210);
    wr(ADDR_CTRL, 32'h260);
    $display("test white black done");
    wr(ADDR_SRC, 1);
    wr(ADDR_GAIN, 0);
    wr(ADDR_ENABLE, 7);
    route_src <= 2'h1;
    gray(700, 64);
    rdchk(ADDR_STATUS, 32'h71);
    route_src <= 2'h0;
    gray(700, 700);
    apb(1'b1, 8'h24, 32'hFFF);
    chk({31'h0, last_err}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rv, 32'h0);
    $display("test source done");
    report_and_stop();
  end
endmodule
